// file: dv/drsi_host.sv
// host model: byte strobes, serial bits and the display reset pin
`timescale 1ns/1ps
module drsi_host (
    input  wire logic       clk,
    output logic            reset_input_n,
    output logic            cmd_data_flag,
    output logic            byte_valid,
    output logic [7:0]      host_data_port,
    output logic            serial_bit_valid,
    output logic            serial_bit
);
    initial begin
        reset_input_n    = 1'b1;
        cmd_data_flag    = 1'b0;
        byte_valid       = 1'b0;
        host_data_port   = 8'h00;
        serial_bit_valid = 1'b0;
        serial_bit       = 1'b0;
    end
    // pin levels change together, off the sampling edge
    task automatic set_pin(input logic rst_n, input logic flag);
        @(negedge clk);
        reset_input_n = rst_n;
        cmd_data_flag = flag;
    endtask
    // high, low, high with a settle wait after each step
    task automatic reset_pulse(input int n);
        set_pin(1'b1, cmd_data_flag);
        repeat (n) @(negedge clk);
        set_pin(1'b0, cmd_data_flag);
        repeat (n) @(negedge clk);
        set_pin(1'b1, cmd_data_flag);
        repeat (n) @(negedge clk);
    endtask
    // one strobe per byte; released port shows the inverse, not a stale copy
    task automatic send_byte(input logic dc, input logic [7:0] b);
        @(negedge clk);
        cmd_data_flag  = dc;
        host_data_port = b;
        byte_valid     = 1'b1;
        @(negedge clk);
        byte_valid     = 1'b0;
        host_data_port = ~b;
    endtask
    // msb first, n leading bits of v
    task automatic send_bits(input logic [7:0] v, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            @(negedge clk);
            serial_bit       = v[i];
            serial_bit_valid = 1'b1;
            @(negedge clk);
            serial_bit_valid = 1'b0;
            serial_bit       = ~v[i];
        end
    endtask
endmodule

// file: dv/tb_drsi_core.sv
// testbench: reset defaults, command decode, reset pin, address, serial
`timescale 1ns/1ps
module tb_drsi_core;
    import drsi_pkg::*;
    logic        clk, reset, reset_input_n, cmd_data_flag, byte_valid;
    logic        serial_bit_valid, serial_bit, serial_byte_done, data_write;
    logic [7:0]  host_data_port, serial_shift, data_byte;
    logic [6:0]  i2c_slave_addr;
    logic [3:0]  serial_count;
    drsi_state_t disp_state, exp;
    int          failures, n_compared, cycles;

    drsi_host drsi_host_inst (.clk, .reset_input_n, .cmd_data_flag, .byte_valid,
        .host_data_port, .serial_bit_valid, .serial_bit);
    drsi_core drsi_core_inst (.clk, .reset, .reset_input_n, .cmd_data_flag,
        .byte_valid, .host_data_port, .serial_bit_valid, .serial_bit, .i2c_slave_addr,
        .disp_state, .serial_shift, .serial_count, .serial_byte_done, .data_write,
        .data_byte);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard, far above the roughly 150 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk_state(input drsi_state_t got, input drsi_state_t want);
        n_compared++;
        if (got !== want) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        n_compared++;
        if (got !== want) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic cmd(input logic [7:0] b);
        drsi_host_inst.send_byte(1'b0, b);
    endtask
    task automatic t_defaults();
        chk_state(disp_state, STATE_RESET);
        chk(disp_state.contrast, 8'h7F);
        chk({4'h0, serial_count}, 8'h00);
        chk({1'b0, i2c_slave_addr}, 8'h3C);
        $display("test defaults done");
    endtask
    task automatic t_commands();
        drsi_host_inst.reset_pulse(8);
        cmd(CMD_DISPLAY_OFF);
        cmd(CMD_MUX_RATIO);
        cmd(8'h3F);
        cmd(8'hAD);
        cmd(8'h8A);
        cmd(CMD_CONTRAST);
        cmd(8'h20);
        cmd(CMD_SEG_REMAP);
        cmd(CMD_COM_REVERSE);
        cmd(CMD_ENTIRE_ON);
        cmd(8'h45);
        cmd(8'h03);
        cmd(8'h12);
        cmd(CMD_DISPLAY_ON);
        exp = '{1'b1, 1'b1, 1'b1, 1'b1, 8'h20, 6'h05, 8'h23, 6'h3F};
        chk_state(disp_state, exp);
        cmd(CMD_NORMAL_MODE);
        exp.entire_on = 1'b0;
        chk_state(disp_state, exp);
        cmd(CMD_SEG_NORMAL);
        cmd(CMD_COM_NORMAL);
        exp.seg_remap   = 1'b0;
        exp.com_reverse = 1'b0;
        chk_state(disp_state, exp);
        drsi_host_inst.send_byte(1'b1, 8'h55);
        for (int i = 0; i < 4 && data_write !== 1'b1; i++) @(negedge clk);
        chk({7'h00, data_write}, 8'h01);
        chk(data_byte, 8'h55);
        $display("test commands done");
    endtask
    task automatic t_reset_pin();
        cmd(CMD_DISPLAY_OFF);
        chk({7'h00, disp_state.display_on}, 8'h00);
        cmd(CMD_DISPLAY_ON);
        cmd(CMD_MUX_RATIO);
        cmd(8'h1F);
        cmd(CMD_SEG_REMAP);
        cmd(CMD_COM_REVERSE);
        cmd(CMD_ENTIRE_ON);
        chk({2'h0, disp_state.mux_ratio}, 8'h1F);
        drsi_host_inst.send_bits(8'hC0, 3);
        chk({4'h0, serial_count}, 8'h03);
        drsi_host_inst.set_pin(1'b0, 1'b0);
        repeat (8) @(negedge clk);
        drsi_host_inst.send_byte(1'b1, 8'h5A);
        chk({7'h00, data_write}, 8'h00);
        cmd(CMD_DISPLAY_ON);
        drsi_host_inst.set_pin(1'b1, 1'b0);
        repeat (8) @(negedge clk);
        chk_state(disp_state, STATE_RESET);
        chk({4'h0, serial_count}, 8'h00);
        chk(serial_shift, 8'h00);
        cmd(CMD_DISPLAY_ON);
        exp = STATE_RESET;
        exp.display_on = 1'b1;
        chk_state(disp_state, exp);
        $display("test reset pin done");
    endtask
    task automatic t_address_serial();
        drsi_host_inst.set_pin(1'b1, 1'b1);
        repeat (6) @(negedge clk);
        chk({1'b0, i2c_slave_addr}, 8'h3D);
        drsi_host_inst.set_pin(1'b1, 1'b0);
        repeat (6) @(negedge clk);
        chk({1'b0, i2c_slave_addr}, 8'h3C);
        drsi_host_inst.send_bits(8'hA5, 8);
        for (int i = 0; i < 4 && serial_byte_done !== 1'b1; i++) @(negedge clk);
        chk({7'h00, serial_byte_done}, 8'h01);
        chk(serial_shift, 8'hA5);
        $display("test address and serial done");
    endtask
    initial begin
        reset = 1'b1;
        failures = 0;
        n_compared = 0;
        cycles = 0;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        repeat (6) @(negedge clk);
        t_defaults();
        t_commands();
        t_reset_pin();
        t_address_serial();
        results();
    end
endmodule

// file: hw/drsi_core.sv
// display driver core: reset defaults, i2c address select, command decode
`timescale 1ns/1ps
module drsi_core
    import drsi_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        reset_input_n,
    input  wire logic        cmd_data_flag,
    input  wire logic        byte_valid,
    input  wire logic [7:0]  host_data_port,
    input  wire logic        serial_bit_valid,
    input  wire logic        serial_bit,
    output logic [6:0]       i2c_slave_addr,
    output drsi_state_t      disp_state,
    output logic [7:0]       serial_shift,
    output logic [3:0]       serial_count,
    output logic             serial_byte_done,
    output logic             data_write,
    output logic [7:0]       data_byte
);
    // three-stage sampling of the pins; change counts when stages 2 and 3 agree
    logic [2:0] rst_sync;
    logic [2:0] dc_sync;
    logic       rst_n_q;
    logic       dc_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            rst_sync <= 3'h0;
            dc_sync  <= 3'h0;
            rst_n_q  <= 1'b0;
            dc_q     <= 1'b0;
        end else begin
            rst_sync <= {rst_sync[1:0], reset_input_n};
            dc_sync  <= {dc_sync[1:0], cmd_data_flag};
            if (rst_sync[1] == rst_sync[2]) begin
                rst_n_q <= rst_sync[2];
            end
            if (dc_sync[1] == dc_sync[2]) begin
                dc_q <= dc_sync[2];
            end
        end
    end

    // display reset held whenever either reset is active
    wire in_reset = reset || !rst_n_q;
    // transfers only counted outside reset; strobes are same-domain
    wire accept   = byte_valid && !in_reset;
    wire is_cmd   = accept && !cmd_data_flag;
    wire is_data  = accept && cmd_data_flag;

    // select pin level forms the address lsb
    assign i2c_slave_addr = {I2C_ADDR_UPPER, dc_q};

    // filtered select level must reach the address lsb one edge later
    property p_addr;
        @(posedge clk) disable iff (reset)
        (!dc_sync[2] && !dc_sync[1]) |=> i2c_slave_addr == 7'h3C;
    endproperty
    a_addr: assert property (p_addr)
        else $error("select low did not give the default address");

    property p_addr_hi;
        @(posedge clk) disable iff (reset)
        (dc_sync[2] && dc_sync[1]) |=> i2c_slave_addr == 7'h3D;
    endproperty
    a_addr_hi: assert property (p_addr_hi)
        else $error("select high did not give the alternate address");

    // command decode wires
    drsi_arg_t  pend;
    drsi_state_t next_state;
    drsi_arg_t  next_pend;
    wire        hit_start = (host_data_port & CMD_START_MASK) == CMD_START_BASE;
    wire        hit_col_lo = (host_data_port & CMD_COL_LO_MASK) == CMD_COL_LO_BASE;
    wire        hit_col_hi = (host_data_port & CMD_COL_LO_MASK) == CMD_COL_HI_BASE;

    // argument bytes follow their opcode; anything else is a single-byte command
    always_comb begin
        next_state = disp_state;
        next_pend  = DRSI_ARG_NONE;
        if (pend == DRSI_ARG_CONTRAST) begin
            next_state.contrast = host_data_port;
        end else if (pend == DRSI_ARG_MUX) begin
            next_state.mux_ratio = host_data_port[5:0];
        end else begin
            case (host_data_port)
                CMD_DISPLAY_OFF: next_state.display_on  = 1'b0;
                CMD_DISPLAY_ON:  next_state.display_on  = 1'b1;
                CMD_NORMAL_MODE: next_state.entire_on   = 1'b0;
                CMD_ENTIRE_ON:   next_state.entire_on   = 1'b1;
                CMD_SEG_NORMAL:  next_state.seg_remap   = 1'b0;
                CMD_SEG_REMAP:   next_state.seg_remap   = 1'b1;
                CMD_COM_NORMAL:  next_state.com_reverse = 1'b0;
                CMD_COM_REVERSE: next_state.com_reverse = 1'b1;
                CMD_CONTRAST:    next_pend = DRSI_ARG_CONTRAST;
                CMD_MUX_RATIO:   next_pend = DRSI_ARG_MUX;
                default: begin
                    if (hit_start) begin
                        next_state.start_line = host_data_port[5:0];
                    end else if (hit_col_lo) begin
                        next_state.column[3:0] = host_data_port[3:0];
                    end else if (hit_col_hi) begin
                        next_state.column[7:4] = host_data_port[3:0];
                    end
                end
            endcase
        end
    end

    // display state: reset defaults win over any command
    always_ff @(posedge clk) begin
        if (in_reset) begin
            disp_state <= STATE_RESET;
            pend       <= DRSI_ARG_NONE;
        end else if (is_cmd) begin
            disp_state <= next_state;
            pend       <= next_pend;
        end
    end

    // defaults held through every pin reset cycle
    property p_reset_defaults;
        @(posedge clk) disable iff (reset)
        !rst_n_q |=> disp_state == STATE_RESET;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("display state not at defaults during reset");

    property p_off_in_reset;
        @(posedge clk) disable iff (reset)
        !rst_n_q |=> !disp_state.display_on;
    endproperty
    a_off_in_reset: assert property (p_off_in_reset)
        else $error("display on while reset held");

    // literal values guard against a wrong package default
    property p_contrast;
        @(posedge clk)
        reset |=> disp_state.contrast == 8'h7F;
    endproperty
    a_contrast: assert property (p_contrast)
        else $error("contrast not 7Fh after reset");

    property p_reset_map;
        @(posedge clk)
        in_reset |=> !disp_state.seg_remap && !disp_state.com_reverse;
    endproperty
    a_reset_map: assert property (p_reset_map)
        else $error("mapping or scan direction not normal after reset");

    property p_reset_addr;
        @(posedge clk)
        in_reset |=> disp_state.start_line == 6'h00 && disp_state.column == 8'h00;
    endproperty
    a_reset_addr: assert property (p_reset_addr)
        else $error("start line or column not zero after reset");

    property p_reset_mode;
        @(posedge clk)
        in_reset |=> disp_state.mux_ratio == 6'h3F && !disp_state.entire_on;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("display mode not at defaults after reset");

    // a display-on opcode outside reset must land on the next edge
    property p_on_cmd;
        @(posedge clk) disable iff (reset)
        (rst_n_q && byte_valid && !cmd_data_flag && pend == DRSI_ARG_NONE
         && host_data_port == 8'hAF) |=> disp_state.display_on;
    endproperty
    a_on_cmd: assert property (p_on_cmd)
        else $error("display-on command not taken");

    // serial shift register, msb first; partial bits dropped by reset
    wire last_bit = serial_count == 4'(SERIAL_BITS - 1);
    always_ff @(posedge clk) begin
        if (in_reset) begin
            serial_shift     <= 8'h00;
            serial_count     <= 4'h0;
            serial_byte_done <= 1'b0;
        end else begin
            serial_byte_done <= serial_bit_valid && last_bit;
            if (serial_bit_valid) begin
                serial_shift <= {serial_shift[6:0], serial_bit};
                serial_count <= last_bit ? 4'h0 : serial_count + 4'h1;
            end
        end
    end

    // partial bits must not survive into the next byte
    property p_shift_clr;
        @(posedge clk)
        in_reset |=> serial_count == 4'h0 && serial_shift == 8'h00;
    endproperty
    a_shift_clr: assert property (p_shift_clr)
        else $error("serial shift not cleared");

    // data bytes pass out registered; column pointer not advanced here
    always_ff @(posedge clk) begin
        if (in_reset) begin
            data_write <= 1'b0;
            data_byte  <= 8'h00;
        end else begin
            data_write <= is_data;
            if (is_data) begin
                data_byte <= host_data_port;
            end
        end
    end

    // bytes in reset vanish; bytes after reset pass unchanged
    property p_ignore;
        @(posedge clk) disable iff (reset)
        (!rst_n_q && byte_valid) |=> !data_write;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("data accepted in reset");

    property p_accept;
        @(posedge clk) disable iff (reset)
        (rst_n_q && byte_valid && cmd_data_flag) |=> data_write;
    endproperty
    a_accept: assert property (p_accept)
        else $error("data ignored after reset");

    property p_data_byte;
        @(posedge clk) disable iff (reset)
        (rst_n_q && byte_valid && cmd_data_flag) |=> data_byte == $past(host_data_port);
    endproperty
    a_data_byte: assert property (p_data_byte)
        else $error("data byte not passed through");
endmodule

// file: hw/drsi_pkg.sv
// package: constants and carrier types for the display reset/init sequencer
package drsi_pkg;
    // reset defaults of the display state, command opcodes and decode masks
    localparam logic [7:0] CONTRAST_RESET  = 8'h7F;
    localparam logic [5:0] START_LINE_RESET = 6'h00;
    localparam logic [7:0] COLUMN_RESET    = 8'h00;
    localparam logic [7:0] CMD_DISPLAY_OFF = 8'hAE;
    localparam logic [7:0] CMD_DISPLAY_ON  = 8'hAF;
    localparam logic [7:0] CMD_NORMAL_MODE = 8'hA4;
    localparam logic [7:0] CMD_ENTIRE_ON   = 8'hA5;
    localparam logic [7:0] CMD_CONTRAST    = 8'h81;
    localparam logic [7:0] CMD_SEG_NORMAL  = 8'hA0;
    localparam logic [7:0] CMD_SEG_REMAP   = 8'hA1;
    localparam logic [7:0] CMD_COM_NORMAL  = 8'hC0;
    localparam logic [7:0] CMD_COM_REVERSE = 8'hC8;
    localparam logic [7:0] CMD_MUX_RATIO   = 8'hA8;
    localparam logic [5:0] MUX_RESET       = 6'h3F;
    localparam logic [7:0] CMD_START_MASK  = 8'hC0;
    localparam logic [7:0] CMD_START_BASE  = 8'h40;
    localparam logic [7:0] CMD_COL_LO_MASK = 8'hF0;
    localparam logic [7:0] CMD_COL_LO_BASE = 8'h00;
    localparam logic [7:0] CMD_COL_HI_BASE = 8'h10;
    // i2c slave address, select pin supplies the lsb
    localparam logic [5:0] I2C_ADDR_UPPER  = 6'h1E;
    localparam int         SERIAL_BITS     = 8;

    typedef struct packed {
        logic       display_on;
        logic       entire_on;
        logic       seg_remap;
        logic       com_reverse;
        logic [7:0] contrast;
        logic [5:0] start_line;
        logic [7:0] column;
        logic [5:0] mux_ratio;
    } drsi_state_t;

    localparam drsi_state_t STATE_RESET = '{
        display_on:  1'b0,
        entire_on:   1'b0,
        seg_remap:   1'b0,
        com_reverse: 1'b0,
        contrast:    CONTRAST_RESET,
        start_line:  START_LINE_RESET,
        column:      COLUMN_RESET,
        mux_ratio:   MUX_RESET
    };

    typedef enum logic [1:0] {
        DRSI_ARG_NONE     = 2'b00,
        DRSI_ARG_CONTRAST = 2'b01,
        DRSI_ARG_MUX      = 2'b10
    } drsi_arg_t;
endpackage
